// ---- src/pifb_pkg.sv ----
/*
 * Package for the peripheral interrupt flag bank: register offsets,
 * bit positions, reset values and the packed carriers of the block.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
`default_nettype none
package pifb_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] PIFB_OFF_FLAGS   = 8'h00; // Event flags, read/write
    localparam logic [7:0] PIFB_OFF_ENABLES = 8'h04; // Per-source enables
    localparam logic [7:0] PIFB_OFF_CTRL    = 8'h08; // Global and peripheral enables
    localparam logic [7:0] PIFB_OFF_STATUS  = 8'h0c; // Sticky status, read-only
    localparam logic [7:0] PIFB_OFF_CLEAR   = 8'h10; // Status clear, write-only
    localparam logic [7:0] PIFB_OFF_IRQEN   = 8'h14; // Status interrupt enables

    // Flag bit positions
    localparam int PIFB_BIT_OSC_FAIL  = 7;
    localparam int PIFB_BIT_CMP_TWO   = 6;
    localparam int PIFB_BIT_CMP_ONE   = 5;
    localparam int PIFB_BIT_NV_DONE   = 4;
    localparam int PIFB_BIT_BUS_COLL  = 3;
    localparam int PIFB_BIT_CAP_TWO   = 0;

    // Implemented bits: 7..3 and 0; bits 2 and 1 read zero
    localparam logic [7:0] PIFB_IMPL_MASK = 8'hf9;
    localparam logic [7:0] PIFB_FLAGS_RST = 8'h00;
    localparam logic [7:0] PIFB_EN_RST    = 8'h00;

    // Control register field positions
    localparam int PIFB_CTRL_GLOBAL = 0;
    localparam int PIFB_CTRL_PERIPH = 1;

    // Status register field positions
    localparam int PIFB_ST_REQ_RISE = 0; // Combined request went high
    localparam int PIFB_ST_WIDTH    = 1;

    // APB request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pifb_apb_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic        global_en;
        logic        periph_en;
        logic [PIFB_ST_WIDTH-1:0] status;
        logic [PIFB_ST_WIDTH-1:0] irq_en;
        logic        req_prev;
        logic [31:0] rdata;
    } pifb_state_t;
endpackage
`default_nettype wire

// ---- src/pifb_bank.sv ----
/*
 * Peripheral interrupt flag bank: six event sources set sticky flags,
 * software reads and clears them over APB, and an enabled flag raises
 * a combined peripheral interrupt request while both master enables are set.
 * Assumes sources are logic on i_clk giving one-cycle event pulses,
 * and a single synchronous reset for the whole block.
 */
`timescale 1ns/10ps
`default_nettype none
module pifb_bank
    import pifb_pkg::*;
(
    input  wire logic        i_clk,            // System clock, 10 MHz
    input  wire logic        i_sys_rst,        // Synchronous reset, active high
    input  wire logic        i_psel,           // APB select
    input  wire logic        i_penable,        // APB access phase
    input  wire logic        i_pwrite,         // APB direction
    input  wire logic [7:0]  i_paddr,          // APB byte address
    input  wire logic [31:0] i_pwdata,         // APB write data
    input  wire logic [3:0]  i_pstrb,          // APB byte strobes
    output logic             o_pready,         // APB ready
    output logic [31:0]      o_prdata,         // APB read data
    output logic             o_pslverr,        // APB error on unmapped address
    input  wire logic        i_osc_fail,       // Oscillator failure event
    input  wire logic        i_cmp_two,        // Comparator two event
    input  wire logic        i_cmp_one,        // Comparator one event
    input  wire logic        i_nv_write_done,  // Nonvolatile write complete
    input  wire logic        i_serial_bus_coll,// Serial bus collision event
    input  wire logic        i_capture_two,    // Capture/compare two event
    output logic             o_periph_irq,     // Combined peripheral request
    output logic             o_irq             // Status interrupt output
);
    pifb_state_t   st_reg;   // All state
    pifb_state_t   st_next;  // Next state
    pifb_apb_req_t req;      // Bundled bus request
    logic [7:0]    events;   // Source events placed at flag positions
    logic          wr_en;    // Write takes effect this edge
    logic          rd_en;    // Read data captured this edge
    logic          mapped;   // Address hits a register
    logic          periph_req; // Combined request, current state

    // Bundle bus signals
    always_comb begin
        req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                paddr: i_paddr, pwdata: i_pwdata};
    end

    // Map sources onto flag positions; unused bits stay zero
    always_comb begin
        events = 8'h00;
        events[PIFB_BIT_OSC_FAIL] = i_osc_fail;
        events[PIFB_BIT_CMP_TWO]  = i_cmp_two;
        events[PIFB_BIT_CMP_ONE]  = i_cmp_one;
        events[PIFB_BIT_NV_DONE]  = i_nv_write_done;
        events[PIFB_BIT_BUS_COLL] = i_serial_bus_coll;
        events[PIFB_BIT_CAP_TWO]  = i_capture_two;
    end

    // Zero-wait slave: every access completes in its first access cycle
    // No register needs a wait, so ready stays high and the master stays simple
    assign o_pready = 1'b1;
    assign wr_en    = req.psel && req.penable && req.pwrite && mapped;
    assign rd_en    = req.psel && !req.pwrite;

    // Address decode
    always_comb begin
        unique case (req.paddr)
            PIFB_OFF_FLAGS, PIFB_OFF_ENABLES, PIFB_OFF_CTRL,
            PIFB_OFF_STATUS, PIFB_OFF_CLEAR, PIFB_OFF_IRQEN: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign o_pslverr = req.psel && req.penable && !mapped;

    // Request needs a matching flag/enable pair plus both master enables
    assign periph_req = (|(st_reg.flags & st_reg.enables))
                        && st_reg.global_en && st_reg.periph_en;

    // Next-state logic for flags, enables, status and read data
    always_comb begin
        st_next = st_reg;
        st_next.req_prev = periph_req;
        // Software writes, only low byte lane carries register data
        if (wr_en && i_pstrb[0]) begin
            unique case (req.paddr)
                PIFB_OFF_FLAGS:   st_next.flags = req.pwdata[7:0] & PIFB_IMPL_MASK;
                PIFB_OFF_ENABLES: st_next.enables = req.pwdata[7:0] & PIFB_IMPL_MASK;
                PIFB_OFF_CTRL: begin
                    st_next.global_en = req.pwdata[PIFB_CTRL_GLOBAL];
                    st_next.periph_en = req.pwdata[PIFB_CTRL_PERIPH];
                end
                PIFB_OFF_CLEAR:   st_next.status = st_reg.status & ~req.pwdata[PIFB_ST_WIDTH-1:0];
                PIFB_OFF_IRQEN:   st_next.irq_en = req.pwdata[PIFB_ST_WIDTH-1:0];
                default: ;
            endcase
        end
        // Events set after any write so a same-cycle clear loses; no enable gates this
        st_next.flags = st_next.flags | (events & PIFB_IMPL_MASK);
        // Rising request is a sticky status event, set wins over clear
        if (periph_req && !st_reg.req_prev) begin
            st_next.status[PIFB_ST_REQ_RISE] = 1'b1;
        end
        // Read data registered in the setup cycle, valid in access phase
        if (rd_en) begin
            unique case (req.paddr)
                PIFB_OFF_FLAGS:   st_next.rdata = {24'h000000, st_reg.flags};
                PIFB_OFF_ENABLES: st_next.rdata = {24'h000000, st_reg.enables};
                PIFB_OFF_CTRL:    st_next.rdata = {30'h00000000, st_reg.periph_en,
                                                   st_reg.global_en};
                PIFB_OFF_STATUS:  st_next.rdata = {{(32-PIFB_ST_WIDTH){1'b0}}, st_reg.status};
                PIFB_OFF_IRQEN:   st_next.rdata = {{(32-PIFB_ST_WIDTH){1'b0}}, st_reg.irq_en};
                default:          st_next.rdata = 32'h00000000; // Clear and unmapped read zero
            endcase
        end
    end

    // State register; every reset clears everything
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= '{flags: PIFB_FLAGS_RST, enables: PIFB_EN_RST, global_en: 1'b0,
                        periph_en: 1'b0, status: '0, irq_en: '0, req_prev: 1'b0,
                        rdata: 32'h00000000};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from registers or from a plain combination of them
    assign o_prdata     = st_reg.rdata;
    assign o_periph_irq = periph_req;
    assign o_irq        = |(st_reg.status & st_reg.irq_en);

    // Software stays responsible for clearing stale flags first

    // Flag and request checks, one clock domain, idle during reset

    AST_EVENT_SETS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmp_one |=> st_reg.flags[PIFB_BIT_CMP_ONE])
        else $error("comparator one event did not set its flag");
    AST_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_reg.flags[PIFB_BIT_OSC_FAIL] && !(wr_en && req.paddr == PIFB_OFF_FLAGS))
        |=> st_reg.flags[PIFB_BIT_OSC_FAIL])
        else $error("flag dropped without a software write");
    AST_NO_ENABLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_capture_two && !st_reg.global_en && st_reg.enables == 8'h00)
        |=> st_reg.flags[PIFB_BIT_CAP_TWO])
        else $error("flag gated by enable");
    AST_UNIMPL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_reg.flags[2:1] == 2'b00 && st_reg.enables[2:1] == 2'b00)
        else $error("unimplemented bits set");
    AST_READ_FLAGS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd_en && !req.penable && req.paddr == PIFB_OFF_FLAGS && !(|events))
        |=> o_prdata[7:0] == $past(st_reg.flags))
        else $error("flag read mismatch");
    AST_WRITE_FLAGS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_en && i_pstrb[0] && req.paddr == PIFB_OFF_FLAGS && !(|events))
        |=> st_reg.flags == ($past(req.pwdata[7:0]) & PIFB_IMPL_MASK))
        else $error("flag write not stored");
    AST_REQ_NEEDS_GLOBAL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_periph_irq |-> st_reg.global_en && st_reg.periph_en)
        else $error("request without master enables");
    AST_REQ_RAISED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_reg.global_en && st_reg.periph_en && st_reg.enables[PIFB_BIT_NV_DONE]
         && st_reg.flags[PIFB_BIT_NV_DONE]) |-> o_periph_irq)
        else $error("enabled flag gave no request");

    // Checks below cover paths that the bench reaches only indirectly
    // With no write and no event pending the whole flag byte holds still
    AST_FLAGS_STILL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!wr_en && !(|events)) |=> st_reg.flags == $past(st_reg.flags))
        else $error("flag byte changed with no event or write");

    // Any event, from any of the six sources, is visible one edge later
    AST_ALL_EVENTS_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (|events) |=> ((st_reg.flags & $past(events)) == $past(events)))
        else $error("source event did not set its flag");

    // Reads have no side effect, so a read never clears a pending flag
    AST_READ_KEEPS_FLAGS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req.psel && !req.pwrite && !(|events)) |=> st_reg.flags == $past(st_reg.flags))
        else $error("read disturbed the flag byte");

    // Enable writes keep the unimplemented pair at zero
    AST_WRITE_ENABLES: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_en && i_pstrb[0] && req.paddr == PIFB_OFF_ENABLES)
        |=> st_reg.enables == ($past(req.pwdata[7:0]) & PIFB_IMPL_MASK))
        else $error("enable write not stored as masked");

    // Enables change only by a write to their own register
    AST_ENABLE_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(wr_en && req.paddr == PIFB_OFF_ENABLES) |=> st_reg.enables == $past(st_reg.enables))
        else $error("enables changed without a write");

    // Reads of either byte register never show the unimplemented pair
    AST_READ_UNIMPL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd_en && !req.penable
         && (req.paddr == PIFB_OFF_FLAGS || req.paddr == PIFB_OFF_ENABLES))
        |=> o_prdata[2:1] == 2'b00)
        else $error("unimplemented bits read as one");

    // Registers are one byte wide or less, so upper read lanes stay zero
    AST_READ_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_prdata[31:8] == 24'h000000)
        else $error("upper read data lanes not zero");

    // No flag paired with its enable means no request, whatever the masters say
    AST_REQ_NEEDS_PAIR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !(|(st_reg.flags & st_reg.enables)) |-> !o_periph_irq)
        else $error("request without an enabled flag");

    // A fresh request is caught in the sticky status bit on the next edge
    AST_STATUS_ON_RISE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_periph_irq && !st_reg.req_prev) |=> st_reg.status[PIFB_ST_REQ_RISE])
        else $error("request rise not recorded in status");

    // Status bit stays set until software writes the clear register
    AST_STATUS_STICKY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_reg.status[PIFB_ST_REQ_RISE] && !(wr_en && req.paddr == PIFB_OFF_CLEAR))
        |=> st_reg.status[PIFB_ST_REQ_RISE])
        else $error("status bit dropped without a clear");
endmodule
`default_nettype wire

// ---- dv/pifb_src_model.sv ----
/* Event source model: registers each fire request into an event one cycle later.
   Assumes requests change just after the rising edge of i_clk. */
`timescale 1ns/10ps
`default_nettype none
module pifb_src_model
    import pifb_pkg::*;
(
    input  wire logic       i_clk,     // System clock
    input  wire logic       i_sys_rst, // Reset, active high
    input  wire logic [5:0] i_fire,    // Requests, oscillator fail on top
    output logic      [5:0] o_evt      // Event pulses to the bank
);
    // Registered so events never change on the sampling edge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_evt <= 6'h00;
        end else begin
            o_evt <= i_fire;
        end
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
/* Self-checking bench for the flag bank: APB master tasks and scenarios.
   Assumes a zero-wait APB slave and the event model beside it. */
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pifb_pkg::*;
;
    logic        i_clk = 1'b0;     // 10 MHz clock
    logic        i_sys_rst = 1'b1; // Held for 16 cycles
    logic        psel = 1'b0;      // APB controls
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [5:0]  fire = 6'h00;     // Event requests
    logic [5:0]  evt;              // Event pulses
    logic        pready, pslverr, pirq, irq, er;
    logic [31:0] prdata, rd;
    int          err_count = 0;
    int          comparisons = 0;

    always #50 i_clk = ~i_clk;

    pifb_src_model u_src (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fire(fire), .o_evt(evt));
    pifb_bank u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'hf), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_osc_fail(evt[5]), .i_cmp_two(evt[4]), .i_cmp_one(evt[3]),
        .i_nv_write_done(evt[2]), .i_serial_bus_coll(evt[1]), .i_capture_two(evt[0]),
        .o_periph_irq(pirq), .o_irq(irq));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h1, 32'h0);
            end_sim();
        end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Request events, then wait until the flags have landed
    task automatic pulse(input logic [5:0] m);
        fire <= m;
        @(posedge i_clk);
        fire <= 6'h00;
        repeat (2) @(posedge i_clk);
    endtask

    task automatic t_events;
        logic [7:0] exp;
        exp = 8'h00;
        rdc(PIFB_OFF_FLAGS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i);
            exp = exp | ((i == 0) ? 8'h01 : (8'h04 << i));
            rdc(PIFB_OFF_FLAGS, {24'h0, exp});
        end
        chk({31'h0, pirq}, 32'h0);
        $display("test events done");
    endtask

    task automatic t_rw;
        apb(1'b1, PIFB_OFF_FLAGS, 32'hff);
        rdc(PIFB_OFF_FLAGS, 32'hf9);
        chk({31'h0, er}, 32'h0);
        apb(1'b1, PIFB_OFF_FLAGS, 32'h0);
        rdc(PIFB_OFF_FLAGS, 32'h0);
        apb(1'b1, PIFB_OFF_ENABLES, 32'hff);
        rdc(PIFB_OFF_ENABLES, 32'hf9);
        rdc(8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test register access done");
    endtask

    task automatic t_irq;
        apb(1'b1, PIFB_OFF_FLAGS, 32'h0);
        apb(1'b1, PIFB_OFF_ENABLES, 32'h01);
        apb(1'b1, PIFB_OFF_CTRL, 32'h03);
        @(posedge i_clk);
        chk({31'h0, pirq}, 32'h0);
        pulse(6'h01);
        chk({31'h0, pirq}, 32'h1);
        apb(1'b1, PIFB_OFF_IRQEN, 32'h01);
        @(posedge i_clk);
        chk({31'h0, irq}, 32'h1);
        rdc(PIFB_OFF_STATUS, 32'h1);
        apb(1'b1, PIFB_OFF_CLEAR, 32'h01);
        @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, PIFB_OFF_CTRL, 32'h01);
        @(posedge i_clk);
        chk({31'h0, pirq}, 32'h0);
        $display("test interrupt done");
    endtask

    // Mid-run reset clears flags, enables, masters, status and requests
    task automatic t_reset;
        apb(1'b1, PIFB_OFF_CTRL, 32'h03);
        pulse(6'h20);
        rdc(PIFB_OFF_FLAGS, 32'h81);
        chk({31'h0, pirq}, 32'h1);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        chk(prdata, 32'h0);
        chk({30'h0, pirq, irq}, 32'h0);
        rdc(PIFB_OFF_FLAGS, {24'h0, PIFB_FLAGS_RST});
        rdc(PIFB_OFF_ENABLES, {24'h0, PIFB_EN_RST});
        rdc(PIFB_OFF_CTRL, 32'h0);
        rdc(PIFB_OFF_STATUS, 32'h0);
        $display("test reset done");
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_events();
        t_rw();
        t_irq();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
